// ==== hw/lis_defs.vh ====
// constants for the loop and interrupt sequencer
`ifndef LIS_DEFS_VH
`define LIS_DEFS_VH
`define LIS_AW 24
`define LIS_CW 16
`define LIS_VEC_STEP 24'h000020
`define LIS_RESET_VEC 24'h000000
`define LIS_BOOT_VEC 24'hff0000
`define LIS_USER_START 24'h000000
`define LIS_NOBOOT_START 24'h010000
`define LIS_EMU_VEC 24'h000000
`define LIS_SHORT_LOOP 24'h000006
`define LIS_SHORT_PEN 3'h4
`define LIS_BIT_PWRDN 1
`define LIS_BIT_STACK 2
`define LIS_BIT_EKERN 3
`define LIS_BIT_USER_IRQ_FIRST 4
`define LIS_GIE_BIT 5
`define LIS_MASK_RST 16'h0001
`define LIS_CTL_RST 16'h0000
`define LIS_SEL_LATCH 2'h0
`define LIS_SEL_MASK 2'h1
`define LIS_SEL_CTL 2'h2
`define LIS_LSTK_DEPTH 4'h8
`endif

// ==== hw/lis_sequencer.v ====
// loop end handling and interrupt dispatch for the program sequencer
//
// Function
// - test and decrement at loop end instruction
// - false test refetches loop begin address
// - true test continues sequentially, pops stacks
// - loop begin fetch follows end fetch directly
// - abort and pops when next instruction executes
// - short loops retained, four nop first pass
// - forever loops end only by explicit pop loop
// - vector is bit index times 0x20
// - powerdown bit1, stack bit2, kernel bit3
// - twelve user lines on bits 4..15
// - emulator first, then bit order priority
// - emulator interrupt can never be masked
// - powerdown blocked only by global enable
// - boot interrupt jumps to boot rom
// - user start zero, or page one no-boot
// - latch on stack overflow or software write
// - service only when eligible and highest
// - vector, push pc and status, clear latch
// - return pops; masked pending served later
// - global enable is control bit five
// - maskable interrupts masked at reset
// - lowest index wins simultaneous latches
`timescale 1ns/1ps
`include "lis_defs.vh"
module lis_sequencer
(
  input wire sys_clk,
  input wire rst_b,
  input wire ex_valid, // an instruction is in execute
  input wire ex_idle, // core is idling
  input wire [23:0] ex_pc, // address of executing instruction
  input wire do_push, // do/until executing
  input wire [23:0] do_begin, // loop begin address
  input wire [23:0] do_end, // loop end address
  input wire do_forever, // forever condition selected
  input wire [15:0] do_count, // iteration count
  input wire loop_pop_sw, // explicit pop loop
  input wire rti_exec, // return from interrupt executing
  input wire [23:0] pc_stack_top, // top of pc stack
  input wire [15:0] arith_status_reg,
  input wire [15:0] mode_status_reg,
  input wire [11:0] user_irq, // user lines, first to last
  input wire emu_irq, // emulator request
  input wire boot_irq, // boot request
  input wire boot_done, // boot code finished
  input wire no_boot, // no-boot option strap
  input wire stack_overflow, // stack overflow event
  input wire reg_wr, // processor register write
  input wire [1:0] reg_sel, // register select
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg fetch_redirect, // take fetch_addr next
  output reg [23:0] fetch_addr,
  output reg pc_push, // push return address
  output reg [23:0] pc_push_data,
  output reg pc_pop,
  output reg stat_push,
  output reg [31:0] stat_push_data,
  output reg stat_pop,
  output reg loop_pop, // loop stacks popped
  output reg [3:0] loop_depth,
  output reg nop_insert // short loop setup bubble
);
  // loop stacks, one array each
  reg [23:0] lbeg [0:7];
  reg [23:0] lend [0:7];
  reg [15:0] lcnt [0:7];
  reg [7:0] lfor; // forever flags
  reg [7:0] lfirst; // first pass not yet seen
  reg [15:0] interrupt_pending_latch;
  reg [15:0] interrupt_mask_bits;
  reg [15:0] interrupt_control_reg;
  reg abort_pend; // termination waiting for next execute
  reg [2:0] pen_cnt; // short loop penalty counter
  reg boot_active; // boot code is running
  wire [2:0] top;
  wire at_end;
  wire last_pass;
  wire global_irq_enable;
  wire [15:0] hw_set;
  wire [15:0] enable;
  wire [15:0] eligible;
  wire [4:0] win;
  wire can_take;
  wire take_irq;
  wire take_emu;
  wire wr_latch;
  wire [23:0] loop_len;
  reg [15:0] clr_bit;
  integer i;

  // priority encoder, lowest index first
  function [4:0] lis_prio;
    input [15:0] v;
    integer k;
    begin
      lis_prio = 5'h00;
      for (k = 15; k >= 0; k = k - 1)
        if (v[k])
          lis_prio = {1'b1, k[3:0]};
    end
  endfunction

  assign top = loop_depth[2:0] - 3'h1;
  assign at_end = ex_valid && (loop_depth != 4'h0) &&
                  (ex_pc == lend[top]);
  assign last_pass = !lfor[top] && (lcnt[top] <= 16'h0001);
  assign loop_len = lend[top] - lbeg[top] + 24'h000001;
  assign global_irq_enable = interrupt_control_reg[`LIS_GIE_BIT];
  // hardware events: user lines and stack overflow
  assign hw_set = {user_irq, 1'b0, stack_overflow, 2'b00};
  // reset and powerdown ignore their mask bits
  assign enable = interrupt_mask_bits | 16'h0003;
  assign eligible = interrupt_pending_latch & enable &
                    {16{global_irq_enable}};
  assign win = lis_prio(eligible);
  // an interrupt is not taken over a loop-end decision; boot and
  // return redirects also win the fetch, so defer rather than lose it
  assign can_take = (ex_valid || ex_idle) && !at_end && !abort_pend &&
                    !boot_irq && !(boot_active && boot_done) &&
                    !(rti_exec && ex_valid);
  assign take_emu = emu_irq && can_take;
  assign take_irq = !take_emu && win[4] && can_take;
  assign wr_latch = reg_wr && (reg_sel == `LIS_SEL_LATCH);

  // latch clear pulse for the serviced bit
  always @*
  begin
    clr_bit = 16'h0000;
    if (take_irq)
      clr_bit[win[3:0]] = 1'b1;
  end

  // interrupt registers; hardware set wins over any clear
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interrupt_pending_latch <= 16'h0000;
      interrupt_mask_bits <= `LIS_MASK_RST;
      interrupt_control_reg <= `LIS_CTL_RST;
    end
    else
    begin
      if (wr_latch)
        interrupt_pending_latch <= reg_wdata | hw_set;
      else
        interrupt_pending_latch <=
          (interrupt_pending_latch & ~clr_bit) | hw_set;
      if (reg_wr && reg_sel == `LIS_SEL_MASK)
        interrupt_mask_bits <= reg_wdata;
      if (reg_wr && reg_sel == `LIS_SEL_CTL)
        interrupt_control_reg <= reg_wdata;
    end
  end

  // register read port, unused select reads zero
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 16'h0000;
    else
      case (reg_sel)
        `LIS_SEL_LATCH: reg_rdata <= interrupt_pending_latch;
        `LIS_SEL_MASK: reg_rdata <= interrupt_mask_bits;
        `LIS_SEL_CTL: reg_rdata <= interrupt_control_reg;
        default: reg_rdata <= 16'h0000;
      endcase
  end

  // loop stacks: push on do, decrement at end, pop on abort
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loop_depth <= 4'h0;
      lfor <= 8'h00;
      lfirst <= 8'h00;
      abort_pend <= 1'b0;
      loop_pop <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
        lbeg[i] <= 24'h000000;
        lend[i] <= 24'h000000;
        lcnt[i] <= 16'h0000;
      end
    end
    else
    begin
      loop_pop <= 1'b0;
      if (abort_pend && ex_valid)
      begin
        // instruction after loop end now executes
        abort_pend <= 1'b0;
        loop_pop <= 1'b1;
        loop_depth <= loop_depth - 4'h1;
      end
      else if (loop_pop_sw && loop_depth != 4'h0)
      begin
        // software exit, no automatic handling
        loop_pop <= 1'b1;
        loop_depth <= loop_depth - 4'h1;
      end
      else if (at_end)
      begin
        lfirst[top] <= 1'b0;
        if (last_pass)
          abort_pend <= 1'b1;
        else if (!lfor[top])
          lcnt[top] <= lcnt[top] - 16'h0001;
      end
      else if (do_push && loop_depth < `LIS_LSTK_DEPTH)
      begin
        // overflow is flagged by the stack block outside
        lbeg[loop_depth[2:0]] <= do_begin;
        lend[loop_depth[2:0]] <= do_end;
        lcnt[loop_depth[2:0]] <= do_count;
        lfor[loop_depth[2:0]] <= do_forever;
        lfirst[loop_depth[2:0]] <= 1'b1;
        loop_depth <= loop_depth + 4'h1;
      end
    end
  end

  // short loop setup bubble on the first pass only
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pen_cnt <= 3'h0;
      nop_insert <= 1'b0;
    end
    else
    begin
      // the trigger cycle already gives the first bubble
      if (at_end && !last_pass && lfirst[top] &&
          loop_len < `LIS_SHORT_LOOP)
        pen_cnt <= `LIS_SHORT_PEN - 3'h1;
      else if (pen_cnt != 3'h0)
        pen_cnt <= pen_cnt - 3'h1;
      nop_insert <= (pen_cnt != 3'h0) ||
                    (at_end && !last_pass && lfirst[top] &&
                     loop_len < `LIS_SHORT_LOOP);
    end
  end

  // fetch redirection and implicit pc/status stack traffic
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fetch_redirect <= 1'b0;
      fetch_addr <= `LIS_RESET_VEC;
      pc_push <= 1'b0;
      pc_push_data <= 24'h000000;
      pc_pop <= 1'b0;
      stat_push <= 1'b0;
      stat_push_data <= 32'h00000000;
      stat_pop <= 1'b0;
      boot_active <= 1'b0;
    end
    else
    begin
      fetch_redirect <= 1'b0;
      pc_push <= 1'b0;
      pc_pop <= 1'b0;
      stat_push <= 1'b0;
      stat_pop <= 1'b0;
      if (boot_irq)
      begin
        // boot cannot be masked
        boot_active <= 1'b1;
        fetch_redirect <= 1'b1;
        fetch_addr <= `LIS_BOOT_VEC;
      end
      else if (boot_active && boot_done)
      begin
        boot_active <= 1'b0;
        fetch_redirect <= 1'b1;
        fetch_addr <= no_boot ? `LIS_NOBOOT_START
                              : `LIS_USER_START;
      end
      else if (at_end && !last_pass)
      begin
        // loop back, fetched right behind the end
        fetch_redirect <= 1'b1;
        fetch_addr <= lbeg[top];
      end
      else if (take_emu || take_irq)
      begin
        fetch_redirect <= 1'b1;
        fetch_addr <= take_emu ? `LIS_EMU_VEC
                    : {20'h00000, win[3:0]} * `LIS_VEC_STEP;
        pc_push <= 1'b1;
        pc_push_data <= ex_pc + 24'h000001;
        stat_push <= 1'b1;
        stat_push_data <= {arith_status_reg, mode_status_reg};
      end
      else if (rti_exec && ex_valid)
      begin
        fetch_redirect <= 1'b1;
        fetch_addr <= pc_stack_top;
        pc_pop <= 1'b1;
        stat_pop <= 1'b1;
      end
    end
  end
endmodule

// ==== test/lis_asserts.sv ====
// port-level checks for the loop and interrupt sequencer
`timescale 1ns/1ps
module lis_asserts
(
  input wire sys_clk,
  input wire rst_b,
  input wire ex_idle,
  input wire [23:0] ex_pc,
  input wire rti_exec,
  input wire [23:0] pc_stack_top,
  input wire [15:0] arith_status_reg,
  input wire [15:0] mode_status_reg,
  input wire emu_irq,
  input wire boot_irq,
  input wire boot_done,
  input wire no_boot,
  input wire fetch_redirect,
  input wire [23:0] fetch_addr,
  input wire pc_push,
  input wire [23:0] pc_push_data,
  input wire pc_pop,
  input wire stat_push,
  input wire [31:0] stat_push_data,
  input wire stat_pop,
  input wire loop_pop,
  input wire [3:0] loop_depth,
  input wire nop_insert
);
  // single clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  reg seen_boot; // boot request not yet closed by boot_done
  // only a boot that is running can be ended
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      seen_boot <= 1'b0;
    else if (boot_irq)
      seen_boot <= 1'b1;
    else if (boot_done)
      seen_boot <= 1'b0;
  AST_PUSH: assert property (pc_push |-> stat_push &&
    pc_push_data == $past(ex_pc) + 24'h000001 &&
    stat_push_data == {$past(arith_status_reg), $past(mode_status_reg)})
    else $error("interrupt entry pushed wrong values");
  AST_VEC: assert property (pc_push |-> fetch_redirect &&
    fetch_addr[4:0] == 5'h00 && fetch_addr[23:9] == 15'h0000)
    else $error("vector not on a 32 word slot");
  AST_EMU: assert property (emu_irq && ex_idle && !boot_irq &&
    !boot_done && !rti_exec && loop_depth == 4'h0 |=>
    pc_push && fetch_addr == 24'h000000)
    else $error("emulator request was blocked");
  AST_POP: assert property (loop_pop |->
    loop_depth == $past(loop_depth) - 4'h1)
    else $error("loop pop without depth drop");
  AST_RTI: assert property (pc_pop |-> stat_pop &&
    fetch_redirect && fetch_addr == $past(pc_stack_top))
    else $error("return did not resume at stack top");
  AST_NOP: assert property ($rose(nop_insert) |->
    nop_insert [*4] ##1 !nop_insert)
    else $error("short loop bubble length wrong");
  AST_BOOT: assert property (boot_irq |=> fetch_redirect &&
    fetch_addr == 24'hff0000)
    else $error("boot request not sent to boot rom");
  AST_START: assert property (seen_boot && boot_done && !boot_irq |=>
    fetch_redirect &&
    fetch_addr == ($past(no_boot) ? 24'h010000 : 24'h000000))
    else $error("user start address wrong");
endmodule
bind lis_sequencer lis_asserts u_chk (.*);

// ==== test/lis_pic_model.sv ====
// stand-in for the peripheral controller driving the user lines
`timescale 1ns/1ps
module lis_pic_model
(
  input wire sys_clk,
  input wire rst_b,
  input wire [11:0] req,
  output reg [11:0] user_irq
);
  // registered so requests change only after a clock edge
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      user_irq <= 12'h000;
    else
      user_irq <= req;
  end
endmodule

// ==== test/lis_sequencer_tb.sv ====
// self-checking bench for the loop and interrupt sequencer
`timescale 1ns/1ps
module lis_sequencer_tb;
  reg sys_clk = 1'b0, rst_b = 1'b0, ex_valid = 1'b0, ex_idle = 1'b1;
  reg do_push = 1'b0, do_forever = 1'b0, loop_pop_sw = 1'b0;
  reg rti_exec = 1'b0, emu_irq = 1'b0, boot_irq = 1'b0, boot_done = 1'b0;
  reg no_boot = 1'b0, stack_overflow = 1'b0, reg_wr = 1'b0;
  reg [23:0] ex_pc = 24'h000200, do_begin = 24'h0, do_end = 24'h0;
  reg [23:0] pc_stack_top = 24'h00abcd; // fixed return address
  reg [15:0] do_count = 16'h0002, reg_wdata = 16'h0000;
  reg [15:0] arith_status_reg = 16'h1234, mode_status_reg = 16'h5678;
  reg [1:0] reg_sel = 2'h3;
  reg [11:0] req = 12'h000; // requests into the partner
  wire [11:0] user_irq;
  wire [15:0] reg_rdata;
  wire [23:0] fetch_addr, pc_push_data;
  wire [31:0] stat_push_data;
  wire [3:0] loop_depth;
  wire fetch_redirect, pc_push, pc_pop, stat_push, stat_pop, loop_pop;
  wire nop_insert;
  integer n_fail = 0, checked = 0;
  // 50 ns period
  always #25 sys_clk = ~sys_clk;
  lis_pic_model pic (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
    .user_irq(user_irq));
  lis_sequencer dut (.*);
  task finish_test;
  begin
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    checked = checked + 1;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      n_fail = n_fail + 1;
    end
  end
  endtask
  // one register write, strobe held for a single edge
  task wr(input [1:0] s, input [15:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [1:0] s, input [15:0] e);
  begin
    @(posedge sys_clk);
    reg_sel <= s;
    repeat (2) @(posedge sys_clk);
    #1 chk("reg", e, reg_rdata);
  end
  endtask
  // bounded wait for an interrupt entry, then judge it
  task wait_push(input [23:0] a);
    integer i;
  begin
    i = 0;
    do
    begin
      @(posedge sys_clk);
      #1 i = i + 1;
    end while (pc_push !== 1'b1 && i < 20);
    if (pc_push !== 1'b1)
    begin
      $display("MISMATCH pc_push exp 1 got %b", pc_push);
      n_fail = n_fail + 1;
      finish_test;
    end
    else
    begin
      chk("vector", a, fetch_addr);
      chk("ret", 24'h000201, pc_push_data);
      chk("status", 32'h12345678, stat_push_data);
    end
  end
  endtask
  // one executed instruction; f is push, forever, rti, pop loop
  task step(input [23:0] pc, input [23:0] e, input [3:0] f);
  begin
    @(posedge sys_clk);
    ex_idle <= 1'b0;
    ex_pc <= pc;
    ex_valid <= 1'b1;
    do_begin <= pc + 24'h000001;
    do_end <= e;
    {do_push, do_forever, rti_exec, loop_pop_sw} <= f;
    @(posedge sys_clk);
    ex_valid <= 1'b0;
    {do_push, rti_exec, loop_pop_sw} <= 3'h0;
    #1;
  end
  endtask
  // one-cycle event pulses, no_boot kept as a level
  task strobe(input [4:0] f);
  begin
    @(posedge sys_clk);
    {no_boot, stack_overflow, boot_irq, boot_done, emu_irq} <= f;
    @(posedge sys_clk);
    {stack_overflow, boot_irq, boot_done, emu_irq} <= 4'h0;
    #1;
  end
  endtask
  task t_irq;
  begin
    rd(2'h1, 16'h0001);
    rd(2'h2, 16'h0000);
    wr(2'h0, 16'h0002);
    @(posedge sys_clk);
    req <= 12'h003;
    @(posedge sys_clk);
    req <= 12'h000;
    rd(2'h0, 16'h0032);
    wr(2'h2, 16'h0020);
    wait_push(24'h000020);
    rd(2'h0, 16'h0030);
    wr(2'h1, 16'hffff);
    wait_push(24'h000080);
    wait_push(24'h0000a0);
    strobe(5'h08);
    wait_push(24'h000040);
    $display("irq test done");
  end
  endtask
  task t_special;
  begin
    wr(2'h2, 16'h0000);
    strobe(5'h01);
    chk("emu", 1'b1, pc_push);
    strobe(5'h04);
    chk("boot", 24'hff0000, fetch_addr);
    strobe(5'h12);
    chk("noboot", 24'h010000, fetch_addr);
    strobe(5'h04);
    chk("reboot", 24'hff0000, fetch_addr);
    strobe(5'h02);
    chk("user", 24'h000000, fetch_addr);
    $display("special test done");
  end
  endtask
  task t_loop;
  begin
    step(24'h0000ff, 24'h000103, 4'h8);
    chk("depth", 4'h1, loop_depth);
    step(24'h000103, 24'h0, 4'h0);
    chk("back", 24'h000100, fetch_addr);
    chk("redir", 1'b1, fetch_redirect);
    chk("nop", 1'b1, nop_insert);
    step(24'h000103, 24'h0, 4'h0);
    chk("exit", 1'b0, fetch_redirect);
    step(24'h000104, 24'h0, 4'h0);
    chk("pop", 1'b1, loop_pop);
    $display("loop test done");
  end
  endtask
  task t_fever;
  begin
    step(24'h0001ff, 24'h00020f, 4'hc);
    step(24'h00020f, 24'h0, 4'h0);
    chk("forever", 24'h000200, fetch_addr);
    step(24'h000210, 24'h0, 4'h1);
    chk("depth", 4'h0, loop_depth);
    step(24'h000400, 24'h0, 4'h2);
    chk("rti", 24'h00abcd, fetch_addr);
    chk("pcpop", 1'b1, pc_pop);
    $display("forever test done");
  end
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_irq;
    t_special;
    t_loop;
    t_fever;
    finish_test;
  end
endmodule
